// ---- logic/pidc_defs.svh ----
// Constants of the setpoint loop controller: offsets, codes, reset values, timing.
`ifndef PIDC_DEFS_SVH
`define PIDC_DEFS_SVH
// Clock period in nanoseconds (125 MHz).
`define PIDC_CLK_NS 8
// Control sample period in nanoseconds (1 ms).
`define PIDC_SAMPLE_NS 1000000
// Detection timer step in nanoseconds (0.1 s).
`define PIDC_STEP_NS 100000000
// Cycle counts derived from the times above.
`define PIDC_SAMPLE_CYC (`PIDC_SAMPLE_NS / `PIDC_CLK_NS)
`define PIDC_STEP_CYC (`PIDC_STEP_NS / `PIDC_CLK_NS)
// Register offsets on the serial register port.
`define PIDC_SETPOINT_OFS 16'h0006
`define PIDC_INSEL_OFS 16'h000F
// Bit of the input-select word that routes the setpoint from the port.
`define PIDC_INSEL_SP_BIT 1
// Reset value of both serial registers.
`define PIDC_REG_RST 16'h0000
// Analog input function codes.
`define PIDC_FUNC_FB 5'h08
`define PIDC_FUNC_SP 5'h09
// Multi-function output codes for feedback low and high.
`define PIDC_DOUT_LOW 6'h28
`define PIDC_DOUT_HIGH 6'h29
// Full scale (100.00 %) in hundredths of a percent.
`define PIDC_FULL 32'sh00002710
// Hundredths per tenth and per whole percent.
`define PIDC_TENTH 32'sh0000000A
`define PIDC_PCT 32'sh00000064
// Samples per tenth of a second and per hundredth of a second.
`define PIDC_SMP_PER_TENTH 32'sh00000064
`define PIDC_SMP_PER_HUND 32'sh0000000A
// Bound on the derivative term before gain, to keep products in range.
`define PIDC_D_BOUND 32'sh000186A0
// Bound on the integral accumulator.
`define PIDC_ACC_BOUND 32'sh3FFFFFFF
// Saturation of the frequency word.
`define PIDC_OUT_MAX 32'sh00007FFF
`endif

// ---- logic/pidc_pkg.sv ----
// Types shared by the setpoint loop controller.
package pidc_pkg;
  // Loop mode selector values.
  typedef enum logic [2:0] {
    PIDC_OFF = 3'h0,
    PIDC_OUT_DEV = 3'h1,
    PIDC_OUT_FB = 3'h2,
    PIDC_ADD_DEV = 3'h3,
    PIDC_ADD_FB = 3'h4
  } pidc_mode_t;
  // Internal signed value in hundredths of a percent of max frequency.
  typedef logic signed [31:0] pidc_val_t;
endpackage

// ---- logic/pidc_tick.sv ----
// Free-running divider giving a one-cycle tick every PERIOD clocks.
`timescale 1ns/1ps
`default_nettype none
module pidc_tick #(
  parameter int unsigned PERIOD = 2
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // One-cycle tick.
  output logic tick
);
  // Cycle counter within one period.
  logic [31:0] cnt;

  // Count up and wrap, pulsing the tick on the wrap.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 32'h00000000;
      tick <= 1'b0;
    end else if (cnt >= 32'(PERIOD - 1)) begin
      cnt <= 32'h00000000;
      tick <= 1'b1;
    end else begin
      cnt <= cnt + 32'h00000001;
      tick <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ---- logic/pidc_detect.sv ----
// Feedback level detector with a timer counted in tenths of a second.
`timescale 1ns/1ps
`default_nettype none
module pidc_detect (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Detection enable, out-of-range condition and step tick.
  input wire logic enable,
  input wire logic cond,
  input wire logic step,
  input wire logic [7:0] limit,
  // Detected flag.
  output logic flag
);
  // Whole steps spent out of range.
  logic [8:0] cnt;
  // All checks below run on the clock and pause while reset is held.
  default clocking cb_det @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  ////////////////////////////////////////////////////////////////////////////
  // step timer restart
  // The timer restarts as soon as the condition goes away.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 9'h000;
      flag <= 1'b0;
    end else if (!enable || !cond) begin
      cnt <= 9'h000;
      flag <= 1'b0;
    end else if (step && !flag) begin
      if (cnt >= {1'b0, limit}) begin
        flag <= 1'b1;
      end else begin
        cnt <= cnt + 9'h001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Out of range while enabled.
  sequence s_out;
    enable && cond;
  endsequence

  a_detect_clear: assert property (!(enable && cond) |=> !flag)
    else $error("detect flag did not clear in range");
  // A raised flag survives any edge at which it is still out of range.
  a_detect_hold: assert property ((flag ##0 s_out) |=> flag)
    else $error("detect flag dropped while out of range");
  // A shortened limit may leave the count above it, hence the bound.
  a_detect_early: assert property ($rose(flag) |->
    $past(step) && $past(cnt) >= {1'b0, $past(limit)})
    else $error("detect flag set before the time elapsed");
endmodule
`default_nettype wire

// ---- logic/pidc_top.sv ----
// Setpoint loop controller: source select, loop math, output fold, detection.
`timescale 1ns/1ps
`default_nettype none
`include "pidc_defs.svh"

// Functional notes
// - setpoint priority terminal, parameter, port
// - terminal 1 code 9 gives setpoint
// - parameter enable 1 uses stored setpoint
// - port bit 1 plus setpoint word
// - both terminals code 9 raise error
// - terminal 1 code 8 gives feedback
// - several feedback sources raise error
// - mode 0 to 4, 0 disables
// - modes 2 and 4 differentiate feedback
// - modes 3 and 4 add frequency command
// - proportional gain scales loop input
// - integral time zero disables integral
// - integral contribution clamped to limit
// - derivative time zero disables derivative
// - loop output clamped to upper limit
// - signed bias added to loop output
// - first-order filter, zero means none
// - sign invert negates loop output
// - output gain multiplies loop output
// - negative output clamped or runs reverse
// - modes 3 and 4 never clamp negatives
// - codes 40 and 41 flag timed detection
// - selection 0 keeps running, clears in range
// - low level 0 to 100 percent
// - low time 0.0 to 25.5 s
// - high level 0 to 100 percent
// - stored setpoint 0.00 to 100.00 percent
module pidc_top import pidc_pkg::*; #(
  parameter int unsigned SAMPLE_CYCLES = `PIDC_SAMPLE_CYC,
  parameter int unsigned STEP_CYCLES = `PIDC_STEP_CYC
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Serial register port.
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [15:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  // Analog terminals, hundredths of a percent, from pins.
  input wire logic [13:0] analog_terminal_1,
  input wire logic [13:0] analog_terminal_2,
  // Input function selectors.
  input wire logic [4:0] analog_in1_function,
  input wire logic [4:0] analog_in2_function,
  // Loop settings.
  input wire logic [2:0] loop_mode_select,
  input wire logic [11:0] proportional_gain,
  input wire logic [11:0] integral_time,
  input wire logic [9:0] integral_limit,
  input wire logic [9:0] derivative_time,
  input wire logic [9:0] output_upper_limit,
  input wire logic signed [10:0] output_bias,
  input wire logic [9:0] output_filter_time,
  input wire logic output_sign_invert,
  input wire logic [11:0] output_gain,
  input wire logic negative_output_reverse_enable,
  input wire logic setpoint_param_enable,
  input wire logic [13:0] setpoint_param_value,
  input wire logic signed [15:0] frequency_command,
  // Detection settings.
  input wire logic [2:0] feedback_check_select,
  input wire logic [6:0] low_detect_level,
  input wire logic [7:0] low_detect_time,
  input wire logic [6:0] high_detect_level,
  input wire logic [7:0] high_detect_time,
  input wire logic [5:0] digital_output_function_0,
  input wire logic [5:0] digital_output_function_1,
  // Drive outputs.
  output logic signed [15:0] output_frequency,
  output logic reverse_run,
  output logic drive_stop,
  output logic signed [15:0] deviation_monitor,
  output logic [13:0] feedback_monitor,
  output logic dual_setpoint_config_error,
  output logic multi_feedback_config_error,
  output logic [1:0] digital_output
);
  ////////////////////////////////////////////////////////////////////////////
  // Signals.
  logic [15:0] setpoint_word;     // Serial setpoint word.
  logic [15:0] input_select_word; // Serial input-select word.
  logic [13:0] a1_s1, a1_s2;      // Terminal 1 synchroniser stages.
  logic [13:0] a2_s1, a2_s2;      // Terminal 2 synchroniser stages.
  logic sample;                   // Control sample tick.
  logic step;                     // Detection step tick.
  pidc_mode_t mode;               // Mode, illegal codes read as off.
  logic loop_on;                  // Controller running.
  pidc_val_t sp;                  // Selected setpoint.
  pidc_val_t fb;                  // Selected feedback.
  pidc_val_t dev;                 // Setpoint minus feedback.
  pidc_val_t d_src;               // Signal being differentiated.
  pidc_val_t prev_src;            // Previous sample of d_src.
  pidc_val_t i_acc;               // Integral accumulator, per sample.
  pidc_val_t filt;                // Filter state.
  pidc_val_t p_term, i_raw, i_term, d_raw, d_term;
  pidc_val_t sum, limited, biased, next_filt;
  pidc_val_t inv, gained, next_out;
  pidc_val_t i_lim, o_lim, ti_div, tf_div;
  logic next_stop;
  logic low_flag, high_flag;

  // Saturate a value to plus or minus a bound.
  function automatic pidc_val_t sat(input pidc_val_t v, input pidc_val_t b);
    if (v > b) begin
      sat = b;
    end else if (v < -b) begin
      sat = -b;
    end else begin
      sat = v;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Tick generators for the sample clock and the detection step.
  pidc_tick #(.PERIOD(SAMPLE_CYCLES)) u_sample (
    .clk(clk),
    .rst_n(rst_n),
    .tick(sample)
  );
  pidc_tick #(.PERIOD(STEP_CYCLES)) u_step (
    .clk(clk),
    .rst_n(rst_n),
    .tick(step)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Serial registers. Unmapped addresses read as zero.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      setpoint_word <= `PIDC_REG_RST;
      input_select_word <= `PIDC_REG_RST;
    end else if (reg_write) begin
      if (reg_addr == `PIDC_SETPOINT_OFS) begin
        setpoint_word <= reg_wdata;
      end
      if (reg_addr == `PIDC_INSEL_OFS) begin
        input_select_word <= reg_wdata;
      end
    end
  end

  // Read data is registered one cycle after the read strobe.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 16'h0000;
    end else if (reg_read) begin
      if (reg_addr == `PIDC_SETPOINT_OFS) begin
        reg_rdata <= setpoint_word;
      end else if (reg_addr == `PIDC_INSEL_OFS) begin
        reg_rdata <= input_select_word;
      end else begin
        reg_rdata <= 16'h0000;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Two-stage synchronisers for the converted terminal words.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      a1_s1 <= 14'h0000;
      a1_s2 <= 14'h0000;
      a2_s1 <= 14'h0000;
      a2_s2 <= 14'h0000;
    end else begin
      a1_s1 <= analog_terminal_1;
      a1_s2 <= a1_s1;
      a2_s1 <= analog_terminal_2;
      a2_s2 <= a2_s1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Source selection and the loop arithmetic.
  always_comb begin
    if (loop_mode_select <= 3'h4) begin
      mode = pidc_mode_t'(loop_mode_select);
    end else begin
      mode = PIDC_OFF;
    end
    loop_on = (mode != PIDC_OFF);
    if (analog_in1_function == `PIDC_FUNC_SP) begin
      sp = pidc_val_t'({18'h00000, a1_s2});
    end else if (setpoint_param_enable) begin
      sp = sat(pidc_val_t'({18'h00000, setpoint_param_value}), `PIDC_FULL);
    end else if (input_select_word[`PIDC_INSEL_SP_BIT]) begin
      sp = pidc_val_t'({16'h0000, setpoint_word});
    end else begin
      sp = 32'sh00000000;
    end
    if (analog_in1_function == `PIDC_FUNC_FB) begin
      fb = pidc_val_t'({18'h00000, a1_s2});
    end else if (analog_in2_function == `PIDC_FUNC_FB) begin
      fb = pidc_val_t'({18'h00000, a2_s2});
    end else begin
      fb = 32'sh00000000;
    end
    dev = sp - fb;
    if (mode == PIDC_OUT_FB || mode == PIDC_ADD_FB) begin
      d_src = -fb;
    end else begin
      d_src = dev;
    end
    p_term = (pidc_val_t'(proportional_gain) * dev) / `PIDC_PCT;
    ti_div = (integral_time == 12'h000) ? 32'sh00000001 :
             pidc_val_t'(integral_time) * `PIDC_SMP_PER_TENTH;
    i_raw = (integral_time == 12'h000) ? 32'sh00000000 :
            sat(i_acc / ti_div, `PIDC_FULL);
    i_lim = pidc_val_t'(integral_limit) * `PIDC_TENTH;
    i_term = sat((pidc_val_t'(proportional_gain) * i_raw) / `PIDC_PCT,
                 i_lim);
    d_raw = sat(pidc_val_t'(derivative_time) * `PIDC_SMP_PER_HUND *
                (d_src - prev_src), `PIDC_D_BOUND);
    d_term = (pidc_val_t'(proportional_gain) * d_raw) / `PIDC_PCT;
    sum = p_term + i_term + d_term;
    o_lim = pidc_val_t'(output_upper_limit) * `PIDC_TENTH;
    limited = sat(sum, o_lim);
    biased = limited + pidc_val_t'(output_bias) * `PIDC_TENTH;
    tf_div = pidc_val_t'(output_filter_time) * `PIDC_SMP_PER_HUND +
             32'sh00000001;
    next_filt = filt + (biased - filt) / tf_div;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Loop state advances once per sample; a disabled loop holds zero state.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      i_acc <= 32'sh00000000;
      prev_src <= 32'sh00000000;
      filt <= 32'sh00000000;
    end else if (!loop_on) begin
      i_acc <= 32'sh00000000;
      prev_src <= 32'sh00000000;
      filt <= 32'sh00000000;
    end else begin
      // no accumulation when off
      // A zero time drops the integral at once, not at the next sample.
      if (integral_time == 12'h000) begin
        i_acc <= 32'sh00000000;
      end else if (sample) begin
        i_acc <= sat(i_acc + dev, `PIDC_ACC_BOUND);
      end
      if (sample) begin
        prev_src <= d_src;
        filt <= next_filt;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output stage: invert, gain, then fold into the output frequency.
  always_comb begin
    inv = output_sign_invert ? -filt : filt;
    gained = (pidc_val_t'(output_gain) * inv) / `PIDC_PCT;
    next_stop = 1'b0;
    if (!loop_on) begin
      next_out = pidc_val_t'(frequency_command);
    end else if (mode == PIDC_ADD_DEV || mode == PIDC_ADD_FB) begin
      next_out = pidc_val_t'(frequency_command) + gained;
    end else if (gained < 32'sh00000000 &&
                 !negative_output_reverse_enable) begin
      next_out = 32'sh00000000;
      next_stop = 1'b1;
    end else begin
      next_out = gained;
    end
    next_out = sat(next_out, `PIDC_OUT_MAX);
  end

  // Registered drive outputs and monitors.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      output_frequency <= 16'sh0000;
      reverse_run <= 1'b0;
      drive_stop <= 1'b0;
      deviation_monitor <= 16'sh0000;
      feedback_monitor <= 14'h0000;
    end else begin
      output_frequency <= next_out[15:0];
      reverse_run <= next_out < 32'sh00000000;
      drive_stop <= next_stop;
      deviation_monitor <= dev[15:0];
      feedback_monitor <= fb[13:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration errors.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dual_setpoint_config_error <= 1'b0;
      multi_feedback_config_error <= 1'b0;
    end else begin
      dual_setpoint_config_error <=
        (analog_in1_function == `PIDC_FUNC_SP) &&
        (analog_in2_function == `PIDC_FUNC_SP);
      multi_feedback_config_error <=
        (analog_in1_function == `PIDC_FUNC_FB) &&
        (analog_in2_function == `PIDC_FUNC_FB);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Feedback low and high detection; the drive keeps running either way.
  // low level in percent
  pidc_detect u_low (
    .clk(clk),
    .rst_n(rst_n),
    .enable(loop_on),
    .cond(fb < pidc_val_t'(low_detect_level) * `PIDC_PCT),
    .step(step),
    .limit(low_detect_time),
    .flag(low_flag)
  );
  pidc_detect u_high (
    .clk(clk),
    .rst_n(rst_n),
    .enable(loop_on),
    .cond(fb > pidc_val_t'(high_detect_level) * `PIDC_PCT),
    .step(step),
    .limit(high_detect_time),
    .flag(high_flag)
  );

  // Multi-function outputs follow their assigned code.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      digital_output <= 2'h0;
    end else begin
      digital_output[0] <=
        (digital_output_function_0 == `PIDC_DOUT_LOW && low_flag) ||
        (digital_output_function_0 == `PIDC_DOUT_HIGH && high_flag);
      digital_output[1] <=
        (digital_output_function_1 == `PIDC_DOUT_LOW && low_flag) ||
        (digital_output_function_1 == `PIDC_DOUT_HIGH && high_flag);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks on the block's own behaviour.
  sequence s_both_sp;
    analog_in1_function == `PIDC_FUNC_SP && analog_in2_function == `PIDC_FUNC_SP;
  endsequence
  sequence s_neg_direct;
    (mode == PIDC_OUT_DEV || mode == PIDC_OUT_FB) &&
    !negative_output_reverse_enable;
  endsequence

  a_dual_sp_err: assert property (@(posedge clk) disable iff (!rst_n)
    s_both_sp |=> dual_setpoint_config_error)
    else $error("dual setpoint error not raised");
  a_multi_fb_err: assert property (@(posedge clk) disable iff (!rst_n)
    multi_feedback_config_error |->
    $past(analog_in1_function) == `PIDC_FUNC_FB &&
    $past(analog_in2_function) == `PIDC_FUNC_FB)
    else $error("feedback error without two feedback sources");
  a_sp_terminal: assert property (@(posedge clk) disable iff (!rst_n)
    analog_in1_function == `PIDC_FUNC_SP |-> sp[13:0] == a1_s2)
    else $error("terminal setpoint not taken first");
  a_sp_port: assert property (@(posedge clk) disable iff (!rst_n)
    (analog_in1_function != `PIDC_FUNC_SP && !setpoint_param_enable &&
     input_select_word[1]) |-> sp[15:0] == setpoint_word)
    else $error("port setpoint not used");
  // The edge that releases reset still clears the outputs, so skip it.
  a_mode_off: assert property (@(posedge clk) disable iff (!rst_n)
    (rst_n && !loop_on ##1 1'b1) |->
    output_frequency == $past(frequency_command))
    else $error("disabled loop did not pass the command");
  a_neg_clamp: assert property (@(posedge clk) disable iff (!rst_n)
    s_neg_direct |=> output_frequency >= 16'sh0000)
    else $error("negative output not clamped");
  a_stop_cause: assert property (@(posedge clk) disable iff (!rst_n)
    drive_stop |-> $past(mode == PIDC_OUT_DEV || mode == PIDC_OUT_FB))
    else $error("stop raised in an adding mode");
  a_integ_off: assert property (@(posedge clk) disable iff (!rst_n)
    (integral_time == 12'h000) |=> i_acc == 32'sh00000000)
    else $error("integral accumulated with zero time");
  a_dout_low: assert property (@(posedge clk) disable iff (!rst_n)
    (low_flag && digital_output_function_0 == `PIDC_DOUT_LOW) |=>
    digital_output[0])
    else $error("low detection output not asserted");
endmodule
`default_nettype wire

// ---- tb/pidc_sensor.sv ----
// Feedback sensor model driving the two converted terminal words.
`timescale 1ns/1ps
`default_nettype none
module pidc_sensor (
  // Clock.
  input wire logic clk,
  // Levels to report.
  input wire logic [13:0] level_1,
  input wire logic [13:0] level_2,
  // Converted words.
  output logic [13:0] word_1,
  output logic [13:0] word_2
);
  // The converter refreshes both words once a cycle.
  always_ff @(posedge clk) begin
    word_1 <= level_1;
    word_2 <= level_2;
  end
endmodule
`default_nettype wire

// ---- tb/tb.sv ----
// Self-checking bench for the setpoint loop controller.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  int bad_count = 0;
  int check_count = 0;
  // Controller inputs, each given a value at time zero except a1 and a2, which the sensor model drives.
  logic wr = 1'b0, rd = 1'b0, inv = 1'b0, rev = 1'b0, spe = 1'b0;
  logic [15:0] addr = 16'h0000, wdata = 16'h0000, rdata;
  logic [13:0] lv1 = 14'h0000, lv2 = 14'h0000, spv = 14'h1388, a1, a2;
  logic [4:0] f1 = 5'h00, f2 = 5'h00;
  logic [2:0] mode = 3'h0;
  logic [11:0] kp = 12'h064, ti = 12'h000, og = 12'h064;
  logic [9:0] il = 10'h3E8, ul = 10'h3E8;
  logic signed [10:0] bias = 11'sh000;
  logic signed [15:0] fcmd = 16'sh04D2, fout;
  logic [6:0] lol = 7'h00, hil = 7'h64;
  logic [5:0] do0 = 6'h28, do1 = 6'h29;
  logic [9:0] td = 10'h000;
  logic [7:0] lot = 8'h00;
  logic signed [15:0] dmon;
  logic [13:0] fmon;
  logic rrun, dstop, dual, multi;
  logic [1:0] dout;
  always #4 clk = ~clk;
  pidc_sensor pidc_sensor_i (.clk(clk), .level_1(lv1), .level_2(lv2),
    .word_1(a1), .word_2(a2));
  // Short sample and step periods keep the run brief.
  pidc_top #(.SAMPLE_CYCLES(8), .STEP_CYCLES(16)) pidc_top_i (
    .clk(clk), .rst_n(rst_n), .reg_write(wr), .reg_read(rd),
    .reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata),
    .analog_terminal_1(a1), .analog_terminal_2(a2),
    .analog_in1_function(f1), .analog_in2_function(f2),
    .loop_mode_select(mode), .proportional_gain(kp), .integral_time(ti),
    .integral_limit(il), .derivative_time(td),
    .output_upper_limit(ul), .output_bias(bias),
    .output_filter_time(10'h000), .output_sign_invert(inv),
    .output_gain(og), .negative_output_reverse_enable(rev),
    .setpoint_param_enable(spe), .setpoint_param_value(spv),
    .frequency_command(fcmd), .feedback_check_select(3'h0),
    .low_detect_level(lol), .low_detect_time(lot),
    .high_detect_level(hil), .high_detect_time(8'h00),
    .digital_output_function_0(do0), .digital_output_function_1(do1),
    .output_frequency(fout), .reverse_run(rrun), .drive_stop(dstop),
    .deviation_monitor(dmon), .feedback_monitor(fmon),
    .dual_setpoint_config_error(dual),
    .multi_feedback_config_error(multi), .digital_output(dout));
  ////////////////////////////////////////////////////////////////////////
  task automatic cmp(input string what, input logic [15:0] exp,
    input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  function automatic logic [15:0] pick(input int sel);
    case (sel)
      0: return fout;
      1: return {14'h0000, dout};
      2: return {14'h0000, dual, multi};
      3: return {14'h0000, rrun, dstop};
      4: return dmon;
      default: return {2'b00, fmon};
    endcase
  endfunction
  // Outputs settle only after sync and a sample tick, so poll boundedly.
  task automatic ev(input string what, input int sel, input logic [15:0] exp);
    int n;
    n = 0;
    repeat (3) @(posedge clk);
    while (pick(sel) !== exp && n < 80) begin
      @(posedge clk);
      n++;
    end
    cmp(what, exp, pick(sel));
  endtask
  task automatic reg_wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic reg_rd(input logic [15:0] a, output logic [15:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    d = rdata;
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    logic [15:0] d;
    reg_rd(16'h0006, d);
    cmp("setpoint reset", 16'h0000, d);
    reg_wr(16'h000F, 16'h0002);
    reg_wr(16'h0006, 16'h1B58);
    reg_wr(16'h0010, 16'hFFFF);
    reg_rd(16'h000F, d);
    cmp("input select", 16'h0002, d);
    reg_rd(16'h0006, d);
    cmp("setpoint", 16'h1B58, d);
    reg_rd(16'h0010, d);
    cmp("unmapped", 16'h0000, d);
    $display("test regs done");
  endtask
  task automatic t_cfg();
    f1 <= 5'h09;
    f2 <= 5'h09;
    ev("dual setpoint", 2, 16'h0002);
    f1 <= 5'h08;
    f2 <= 5'h08;
    ev("multi feedback", 2, 16'h0001);
    f2 <= 5'h00;
    ev("one feedback", 2, 16'h0000);
    $display("test cfg done");
  endtask
  task automatic t_loop();
    ev("mode 0", 0, 16'h04D2);
    lv1 <= 14'h07D0;
    spe <= 1'b1;
    mode <= 3'h1;
    ev("mode 1", 0, 16'h0BB8);
    kp <= 12'h0C8;
    ev("p gain", 0, 16'h1770);
    ul <= 10'h190;
    bias <= 11'sh00A;
    ev("limit bias", 0, 16'h1004);
    og <= 12'h0C8;
    ev("out gain", 0, 16'h2008);
    kp <= 12'h064;
    ul <= 10'h3E8;
    bias <= 11'sh000;
    og <= 12'h064;
    ti <= 12'h00A;
    il <= 10'h000;
    mode <= 3'h3;
    ev("mode 3", 0, 16'h108A);
    $display("test loop done");
  endtask
  task automatic t_sign();
    ti <= 12'h000;
    il <= 10'h3E8;
    mode <= 3'h1;
    inv <= 1'b1;
    ev("clamp", 0, 16'h0000);
    ev("stop flag", 3, 16'h0001);
    rev <= 1'b1;
    ev("reverse", 0, 16'hF448);
    ev("run flag", 3, 16'h0002);
    mode <= 3'h2;
    ev("mode 2", 0, 16'hF448);
    mode <= 3'h4;
    rev <= 1'b0;
    ev("mode 4", 0, 16'hF91A);
    inv <= 1'b0;
    $display("test sign done");
  endtask
  task automatic t_prio();
    mode <= 3'h1;
    f1 <= 5'h09;
    lv1 <= 14'h1770;
    f2 <= 5'h08;
    lv2 <= 14'h07D0;
    ev("terminal sp", 0, 16'h0FA0);
    f1 <= 5'h00;
    spe <= 1'b0;
    td <= 10'h001;
    ev("d kick", 0, 16'h2710);
    ev("port sp", 0, 16'h1388);
    ev("deviation", 4, 16'h1388);
    ev("feedback", 5, 16'h07D0);
    $display("test prio done");
  endtask
  task automatic t_det();
    lot <= 8'h02;
    lol <= 7'h32;
    repeat (20) @(posedge clk);
    cmp("low early", 16'h0000, {14'h0000, dout});
    ev("low flag", 1, 16'h0001);
    lv2 <= 14'h2328;
    hil <= 7'h50;
    ev("high flag", 1, 16'h0002);
    lv2 <= 14'h1388;
    ev("in range", 1, 16'h0000);
    $display("test det done");
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_cfg();
    t_loop();
    t_sign();
    t_prio();
    t_det();
    close_out();
  end
  // Watchdog well past the longest run the polls allow, about two thousand cycles.
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    close_out();
  end
endmodule
`default_nettype wire
